// File: hw/mmn_pkg.sv
// constants for the move, multiply and negate execution block
package mmn_pkg;
  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [3:0] OPC_MOVE_SRC  = 4'hC;
  localparam logic [3:0] OPC_MOVE_DST  = 4'hF;
  localparam logic [7:0] OPC_LOAD_BANK = 8'h01;
  localparam logic [7:0] OPC_LOAD_LIT  = 8'h0E;
  localparam logic [7:0] OPC_MUL_LIT   = 8'h0D;
  localparam logic [6:0] OPC_MUL_FILE  = 7'h01;
  localparam logic [6:0] OPC_STORE     = 7'h37;
  localparam logic [6:0] OPC_NEGATE    = 7'h36;
  // ----------------------------------------------------------------
  // data space
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_PROGRAM_COUNTER_LOW = 12'hFF9;
  localparam logic [11:0] ADDR_STACK_TOP_LOW       = 12'hFFD;
  localparam logic [11:0] ADDR_STACK_TOP_HIGH      = 12'hFFE;
  localparam logic [11:0] ADDR_STACK_TOP_UPPER     = 12'hFFF;
  localparam logic [7:0]  INDEXED_LIMIT            = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT_EXT         = 8'h60;
  localparam logic [7:0]  ACCESS_SPLIT_STD         = 8'h80;
  localparam logic [3:0]  ACCESS_HIGH_BANK         = 4'hF;
  // ----------------------------------------------------------------
  // software register map and fields
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_CTRL     = 3'h0;
  localparam logic [2:0] REG_ACC      = 3'h1;
  localparam logic [2:0] REG_BANK     = 3'h2;
  localparam logic [2:0] REG_PROD_LO  = 3'h3;
  localparam logic [2:0] REG_PROD_HI  = 3'h4;
  localparam logic [2:0] REG_STATUS   = 3'h5;
  localparam logic [2:0] REG_INDEX_LO = 3'h6;
  localparam logic [2:0] REG_INDEX_HI = 3'h7;
  localparam int FLD_EXT_EN = 0;
  localparam int FLD_C      = 0;
  localparam int FLD_DC     = 1;
  localparam int FLD_Z      = 2;
  localparam int FLD_OV     = 3;
  localparam int FLD_N      = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIB  = 4'h0;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} mmn_phase_t;
endpackage

// File: hw/mmn_exec.sv
// execution of file move, bank load, literal load, store, multiply, negate
`timescale 1ns/1ps
module mmn_exec (
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic [15:0] i_instr,
  output logic             o_fetch,
  output logic [11:0]      o_mem_addr,
  output logic             o_mem_rd,
  output logic             o_mem_wr,
  output logic [7:0]       o_mem_wdata,
  input  wire logic [7:0]  i_mem_rdata,
  input  wire logic [2:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [7:0]       o_reg_rdata
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mmn_pkg::mmn_phase_t ph_ff;
  logic [15:0] ir_ff;
  logic        second_ff;
  logic [7:0]  move_data_ff;
  logic [7:0]  opnd_ff;
  logic [7:0]  acc_ff;
  logic [3:0]  bank_ff;
  logic [15:0] prod_ff;
  logic [4:0]  status_ff;
  logic        ext_en_ff;
  logic [11:0] index_ff;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic        is_move, is_ldb, is_ldl, is_mull, is_mulf, is_sto, is_neg;
  logic        needs_read, dst_reserved;
  logic [11:0] file_addr;
  logic [7:0]  neg_val;
  logic [7:0]  nxt_mul_op;

  // second word of a move is never decoded as an instruction
  assign is_move = !second_ff && ir_ff[15:12] == mmn_pkg::OPC_MOVE_SRC;
  assign is_ldb  = !second_ff && ir_ff[15:8] == mmn_pkg::OPC_LOAD_BANK;
  assign is_ldl  = !second_ff && ir_ff[15:8] == mmn_pkg::OPC_LOAD_LIT;
  assign is_mull = !second_ff && ir_ff[15:8] == mmn_pkg::OPC_MUL_LIT;
  assign is_mulf = !second_ff && ir_ff[15:9] == mmn_pkg::OPC_MUL_FILE;
  assign is_sto  = !second_ff && ir_ff[15:9] == mmn_pkg::OPC_STORE;
  assign is_neg  = !second_ff && ir_ff[15:9] == mmn_pkg::OPC_NEGATE;
  assign needs_read = is_move || is_mulf || is_neg;
  assign neg_val    = 8'h00 - i_mem_rdata;
  assign nxt_mul_op = is_mull ? ir_ff[7:0] : opnd_ff;

  // program counter low and the three stack-top bytes are off limits
  assign dst_reserved = ir_ff[11:0] == mmn_pkg::ADDR_PROGRAM_COUNTER_LOW ||
                        ir_ff[11:0] == mmn_pkg::ADDR_STACK_TOP_LOW ||
                        ir_ff[11:0] == mmn_pkg::ADDR_STACK_TOP_HIGH ||
                        ir_ff[11:0] == mmn_pkg::ADDR_STACK_TOP_UPPER;

  // operand address: indexed, access bank or selected bank
  always_comb begin
    if (ir_ff[8]) begin
      file_addr = {bank_ff, ir_ff[7:0]};
    end else if (ext_en_ff && ir_ff[7:0] <= mmn_pkg::INDEXED_LIMIT) begin
      file_addr = index_ff + {4'h0, ir_ff[7:0]};
    end else if (ir_ff[7:0] < (ext_en_ff ? mmn_pkg::ACCESS_SPLIT_EXT
                                          : mmn_pkg::ACCESS_SPLIT_STD)) begin
      file_addr = {4'h0, ir_ff[7:0]};
    end else begin
      file_addr = {mmn_pkg::ACCESS_HIGH_BANK, ir_ff[7:0]};
    end
  end

  // ----------------------------------------------------------------
  // phase sequencer and fetch
  // ----------------------------------------------------------------
  // four clock edges make one instruction cycle
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ph_ff <= mmn_pkg::PH_Q1;
    end else begin
      unique case (ph_ff)
        mmn_pkg::PH_Q1: ph_ff <= mmn_pkg::PH_Q2;
        mmn_pkg::PH_Q2: ph_ff <= mmn_pkg::PH_Q3;
        mmn_pkg::PH_Q3: ph_ff <= mmn_pkg::PH_Q4;
        mmn_pkg::PH_Q4: ph_ff <= mmn_pkg::PH_Q1;
      endcase
    end
  end

  // fetch strobe stands through q4; word is taken at its end
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fetch   <= 1'b0;
      ir_ff     <= 16'h0000;
      second_ff <= 1'b0;
    end else begin
      o_fetch <= ph_ff == mmn_pkg::PH_Q3;
      if (ph_ff == mmn_pkg::PH_Q4) begin
        ir_ff     <= i_instr;
        second_ff <= is_move;
      end
    end
  end

  // ----------------------------------------------------------------
  // data memory port
  // ----------------------------------------------------------------
  // read high in q2, data back in q3, write high in q4
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mem_rd    <= 1'b0;
      o_mem_wr    <= 1'b0;
      o_mem_addr  <= 12'h000;
      o_mem_wdata <= mmn_pkg::RST_BYTE;
    end else begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      if (ph_ff == mmn_pkg::PH_Q1) begin
        // second move cycle has no read at all
        o_mem_rd   <= needs_read;
        o_mem_addr <= is_move ? ir_ff[11:0] : file_addr;
      end else if (ph_ff == mmn_pkg::PH_Q3) begin
        if (second_ff) begin
          o_mem_wr    <= ir_ff[15:12] == mmn_pkg::OPC_MOVE_DST && !dst_reserved;
          o_mem_addr  <= ir_ff[11:0];
          o_mem_wdata <= move_data_ff;
        end else begin
          o_mem_wr    <= is_sto || is_neg;
          o_mem_addr  <= file_addr;
          o_mem_wdata <= is_sto ? acc_ff : neg_val;
        end
      end
    end
  end

  // operand capture at end of q3
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      opnd_ff      <= mmn_pkg::RST_BYTE;
      move_data_ff <= mmn_pkg::RST_BYTE;
    end else if (ph_ff == mmn_pkg::PH_Q3 && needs_read) begin
      opnd_ff <= i_mem_rdata;
      if (is_move) begin
        move_data_ff <= i_mem_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // core registers: instruction wins over a software write
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_ff <= mmn_pkg::RST_BYTE;
    end else if (ph_ff == mmn_pkg::PH_Q4 && is_ldl) begin
      acc_ff <= ir_ff[7:0];
    end else if (i_reg_wr && i_reg_addr == mmn_pkg::REG_ACC) begin
      acc_ff <= i_reg_wdata;
    end
  end

  // only the low nibble is stored, so the top always reads zero
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bank_ff <= mmn_pkg::RST_NIB;
    end else if (ph_ff == mmn_pkg::PH_Q4 && is_ldb) begin
      bank_ff <= ir_ff[3:0];
    end else if (i_reg_wr && i_reg_addr == mmn_pkg::REG_BANK) begin
      bank_ff <= i_reg_wdata[3:0];
    end
  end

  // product pair written in q4 of the single cycle
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prod_ff <= 16'h0000;
    end else if (ph_ff == mmn_pkg::PH_Q4 && (is_mull || is_mulf)) begin
      prod_ff <= acc_ff * nxt_mul_op;
    end else if (i_reg_wr && i_reg_addr == mmn_pkg::REG_PROD_LO) begin
      prod_ff[7:0] <= i_reg_wdata;
    end else if (i_reg_wr && i_reg_addr == mmn_pkg::REG_PROD_HI) begin
      prod_ff[15:8] <= i_reg_wdata;
    end
  end

  // flags move only on negate; multiply never reports a zero product
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_ff <= 5'h00;
    end else if (ph_ff == mmn_pkg::PH_Q4 && is_neg) begin
      status_ff[mmn_pkg::FLD_C]  <= opnd_ff == 8'h00;
      status_ff[mmn_pkg::FLD_DC] <= opnd_ff[3:0] == 4'h0;
      status_ff[mmn_pkg::FLD_Z]  <= opnd_ff == 8'h00;
      status_ff[mmn_pkg::FLD_OV] <= opnd_ff == 8'h80;
      status_ff[mmn_pkg::FLD_N]  <= opnd_ff[7] ^ (opnd_ff != 8'h00 && opnd_ff != 8'h80);
    end else if (i_reg_wr && i_reg_addr == mmn_pkg::REG_STATUS) begin
      status_ff <= i_reg_wdata[4:0];
    end
  end

  // control and index base, software only
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ext_en_ff <= 1'b0;
      index_ff  <= 12'h000;
    end else if (i_reg_wr) begin
      if (i_reg_addr == mmn_pkg::REG_CTRL) begin
        ext_en_ff <= i_reg_wdata[mmn_pkg::FLD_EXT_EN];
      end
      if (i_reg_addr == mmn_pkg::REG_INDEX_LO) begin
        index_ff[7:0] <= i_reg_wdata;
      end
      if (i_reg_addr == mmn_pkg::REG_INDEX_HI) begin
        index_ff[11:8] <= i_reg_wdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= mmn_pkg::RST_BYTE;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        mmn_pkg::REG_CTRL:     o_reg_rdata <= {7'h00, ext_en_ff};
        mmn_pkg::REG_ACC:      o_reg_rdata <= acc_ff;
        mmn_pkg::REG_BANK:     o_reg_rdata <= {4'h0, bank_ff};
        mmn_pkg::REG_PROD_LO:  o_reg_rdata <= prod_ff[7:0];
        mmn_pkg::REG_PROD_HI:  o_reg_rdata <= prod_ff[15:8];
        mmn_pkg::REG_STATUS:   o_reg_rdata <= {3'h0, status_ff};
        mmn_pkg::REG_INDEX_LO: o_reg_rdata <= index_ff[7:0];
        mmn_pkg::REG_INDEX_HI: o_reg_rdata <= {4'h0, index_ff[11:8]};
      endcase
    end else begin
      o_reg_rdata <= mmn_pkg::RST_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  property p_move_reserved;
    o_mem_wr && second_ff |-> !dst_reserved;
  endproperty
  a_move_reserved: assert property (p_move_reserved)
    else $error("move wrote a forbidden destination");

  property p_move_timing;
    (ph_ff == mmn_pkg::PH_Q2 && is_move && o_mem_rd) |->
      ##6 (second_ff && ph_ff == mmn_pkg::PH_Q4 &&
           (o_mem_wr == (ir_ff[15:12] == mmn_pkg::OPC_MOVE_DST && !dst_reserved)));
  endproperty
  a_move_timing: assert property (p_move_timing)
    else $error("move write not in q4 of second cycle");

  property p_no_dummy_read;
    second_ff |-> !o_mem_rd;
  endproperty
  a_no_dummy_read: assert property (p_no_dummy_read)
    else $error("read seen in second move cycle");

  property p_bank_read;
    i_reg_rd && i_reg_addr == mmn_pkg::REG_BANK |=> o_reg_rdata[7:4] == 4'h0;
  endproperty
  a_bank_read: assert property (p_bank_read)
    else $error("bank selector upper bits not zero");

  property p_load_lit;
    ph_ff == mmn_pkg::PH_Q4 && is_ldl |=>
      acc_ff == $past(ir_ff[7:0]) && $stable(status_ff);
  endproperty
  a_load_lit: assert property (p_load_lit)
    else $error("literal load wrong");

  property p_mul_lit;
    ph_ff == mmn_pkg::PH_Q4 && is_mull |=>
      prod_ff == $past(acc_ff) * $past(ir_ff[7:0]) && $stable(acc_ff);
  endproperty
  a_mul_lit: assert property (p_mul_lit)
    else $error("literal multiply product wrong");

  property p_mul_file;
    ph_ff == mmn_pkg::PH_Q4 && is_mulf |=>
      prod_ff == $past(acc_ff) * $past(opnd_ff) && $stable(acc_ff);
  endproperty
  a_mul_file: assert property (p_mul_file)
    else $error("file multiply product wrong");

  property p_mul_flags;
    ph_ff == mmn_pkg::PH_Q4 && (is_mull || is_mulf) |=> $stable(status_ff);
  endproperty
  a_mul_flags: assert property (p_mul_flags)
    else $error("multiply changed a flag");

  property p_negate;
    ph_ff == mmn_pkg::PH_Q3 && is_neg |=>
      o_mem_wr && o_mem_wdata == 8'h00 - $past(i_mem_rdata) ##1
      status_ff[mmn_pkg::FLD_Z] == (o_mem_wdata == 8'h00);
  endproperty
  a_negate: assert property (p_negate)
    else $error("negate result or zero flag wrong");

  property p_phases;
    (o_mem_rd |-> ph_ff == mmn_pkg::PH_Q2) and (o_mem_wr |-> ph_ff == mmn_pkg::PH_Q4);
  endproperty
  a_phases: assert property (p_phases)
    else $error("memory strobe in wrong phase");
endmodule // mmn_exec

// File: verification/mmn_mem_model.sv
// data memory model for the move, multiply and negate block
`timescale 1ns/1ps
module mmn_mem_model (
  input  wire logic        i_ref_clk,
  input  wire logic [11:0] i_addr,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wdata,
  output logic [7:0]       o_rdata
);
  // every location of the 12-bit space is backed
  logic [7:0] mem [4096];
  initial o_rdata = 8'h00;
  // answer the cycle after the strobe; otherwise invert so stale data never matches
  always @(posedge i_ref_clk) begin
    if (i_rd) o_rdata <= mem[i_addr];
    else o_rdata <= ~o_rdata;
    if (i_wr) mem[i_addr] <= i_wdata;
  end
endmodule // mmn_mem_model

// File: verification/mmn_exec_tb_top.sv
// self-checking bench for the move, multiply and negate block
`timescale 1ns/1ps
module mmn_exec_tb_top;
  logic        i_ref_clk, i_resetn, i_reg_wr, i_reg_rd, rd_q, o_fetch, o_mem_rd, o_mem_wr;
  logic [15:0] i_instr;
  logic [11:0] o_mem_addr;
  logic [7:0]  i_mem_rdata, i_reg_wdata, o_reg_rdata, o_mem_wdata;
  logic [2:0]  i_reg_addr;
  logic [31:0] seed;
  int          err_count, comparisons;
  logic [7:0]  q_reg[$];
  logic [11:0] q_rd[$];
  logic [19:0] q_wr[$];

  mmn_exec dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_instr(i_instr),
    .o_fetch(o_fetch), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata));
  mmn_mem_model u_mem (.i_ref_clk(i_ref_clk), .i_addr(o_mem_addr), .i_rd(o_mem_rd),
    .i_wr(o_mem_wr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

  // --------------------------------------------------------------
  // clock, random source, checks
  // --------------------------------------------------------------
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic tally(input string what, input logic [19:0] e, input logic [19:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_reg(input logic [7:0] e, input logic [7:0] g);
    tally("reg_rdata", 20'(e), 20'(g));
  endtask
  task automatic chk_rd(input logic [11:0] e, input logic [11:0] g);
    tally("mem_rd_addr", 20'(e), 20'(g));
  endtask
  task automatic chk_wr(input logic [19:0] e, input logic [19:0] g);
    tally("mem_wr_addr_data", e, g);
  endtask
  // monitor: every result takes the oldest note; an unexpected strobe meets x and fails
  always @(posedge i_ref_clk) rd_q <= i_reg_rd;
  always @(negedge i_ref_clk) begin
    if (rd_q === 1'b1) chk_reg(q_reg.size() != 0 ? q_reg.pop_front() : 8'hxx, o_reg_rdata);
    if (o_mem_rd === 1'b1) chk_rd(q_rd.size() != 0 ? q_rd.pop_front() : 12'hxxx, o_mem_addr);
    if (o_mem_wr === 1'b1) chk_wr(q_wr.size() != 0 ? q_wr.pop_front() : 20'hxxxxx,
      {o_mem_addr, o_mem_wdata});
  end

  // --------------------------------------------------------------
  // drivers
  // --------------------------------------------------------------
  // two cycles per access so a strobe is never assigned twice in one step
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
    q_reg.push_back(e);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  // word is taken at the edge closing the fetch cycle
  task automatic issue(input logic [15:0] w);
    int n;
    n = 0;
    i_instr <= w;
    do begin
      @(negedge i_ref_clk);
      n++;
    end while (o_fetch !== 1'b1 && n < 5);
    tally("fetch", 20'h00001, 20'(o_fetch));
    @(posedge i_ref_clk);
  endtask
  // a no-op after the word lets its register updates land
  task automatic run(input logic [15:0] w);
    issue(w);
    issue(16'h0000);
  endtask
  function automatic logic [11:0] acc_addr(input logic e, input logic [7:0] f, input logic [11:0] bs);
    if (e && f <= 8'h5F) return bs + 12'(f);
    return (f < (e ? mmn_pkg::ACCESS_SPLIT_EXT : mmn_pkg::ACCESS_SPLIT_STD)) ? {4'h0, f} : {4'hF, f};
  endfunction
  task automatic results();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // generous bound: the sequence needs well under ten thousand cycles
  initial begin
    #200000;
    err_count++;
    results();
  end

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    logic [7:0]  a, k, s, b, f, x, d;
    logic [15:0] p;
    logic [11:0] bs, src, dst;
    seed = 32'h7591_d5b3;
    {i_resetn, i_reg_wr, i_reg_rd, rd_q, i_instr, i_reg_addr, i_reg_wdata} = '0;
    err_count = 0;
    comparisons = 0;
    repeat (3) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    for (int r = 0; r < 8; r++) reg_rd(3'(r), 8'h00);
    // literal ops, both multiplies and store through the bank selector
    for (int i = 0; i < 6; i++) begin
      a = 8'(rnd());
      k = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'(rnd());
      if (i == 1) a = 8'hFF;
      b = 8'(rnd());
      s = 8'(rnd()) & 8'h1F;
      f = 8'(rnd());
      d = 8'(rnd());
      reg_wr(mmn_pkg::REG_STATUS, s);
      run({mmn_pkg::OPC_LOAD_BANK, b});
      run({mmn_pkg::OPC_LOAD_LIT, a});
      run({mmn_pkg::OPC_MUL_LIT, k});
      p = 16'(a) * 16'(k);
      reg_rd(mmn_pkg::REG_BANK, {4'h0, b[3:0]});
      reg_rd(mmn_pkg::REG_PROD_LO, p[7:0]);
      reg_rd(mmn_pkg::REG_PROD_HI, p[15:8]);
      reg_rd(mmn_pkg::REG_STATUS, s);
      u_mem.mem[{b[3:0], f}] = d;
      q_rd.push_back({b[3:0], f});
      run({mmn_pkg::OPC_MUL_FILE, 1'b1, f});
      p = 16'(a) * 16'(d);
      reg_rd(mmn_pkg::REG_PROD_LO, p[7:0]);
      reg_rd(mmn_pkg::REG_PROD_HI, p[15:8]);
      reg_rd(mmn_pkg::REG_ACC, a);
      q_wr.push_back({b[3:0], f, a});
      run({mmn_pkg::OPC_STORE, 1'b1, f});
      reg_rd(mmn_pkg::REG_STATUS, s);
    end
    // access bank and indexed offset, base chosen to wrap
    bs = 12'hFF0;
    reg_wr(mmn_pkg::REG_INDEX_LO, bs[7:0]);
    reg_wr(mmn_pkg::REG_INDEX_HI, {4'h0, bs[11:8]});
    for (int e = 0; e < 2; e++) begin
      reg_wr(mmn_pkg::REG_CTRL, 8'(e));
      for (int j = 0; j < 5; j++) begin
        f = (j == 0) ? 8'h5F : (j == 1) ? 8'h60 : (j == 2) ? 8'h7F : 8'h80;
        dst = (j == 4) ? {b[3:0], f} : acc_addr(e[0], f, bs);
        q_wr.push_back({dst, a});
        run({mmn_pkg::OPC_STORE, (j == 4), f});
      end
    end
    reg_wr(mmn_pkg::REG_CTRL, 8'h00);
    // negate with the flag corner cases first
    for (int j = 0; j < 6; j++) begin
      x = (j == 0) ? 8'h00 : (j == 1) ? 8'h80 : (j == 2) ? 8'h3A : (j == 3) ? 8'h10 : 8'(rnd());
      f = 8'(rnd());
      d = ~x + 8'h01;
      u_mem.mem[{b[3:0], f}] = x;
      q_rd.push_back({b[3:0], f});
      q_wr.push_back({b[3:0], f, d});
      run({mmn_pkg::OPC_NEGATE, 1'b1, f});
      reg_rd(mmn_pkg::REG_STATUS, {3'b000, d[7], x == 8'h80, x == 8'h00, x[3:0] == 4'h0,
        x == 8'h00});
    end
    // file move: protected destinations write nothing, second cycle reads nothing
    for (int j = 0; j < 7; j++) begin
      src = (j == 4) ? 12'hFFF : 12'(rnd());
      dst = (j == 0) ? mmn_pkg::ADDR_PROGRAM_COUNTER_LOW : (j == 1) ? mmn_pkg::ADDR_STACK_TOP_LOW :
        (j == 2) ? mmn_pkg::ADDR_STACK_TOP_HIGH : (j == 3) ? mmn_pkg::ADDR_STACK_TOP_UPPER :
        (j == 4) ? 12'h000 : 12'(rnd()) & 12'h7FF;
      d = 8'(rnd());
      u_mem.mem[src] = d;
      q_rd.push_back(src);
      if (j >= 4) q_wr.push_back({dst, d});
      issue({mmn_pkg::OPC_MOVE_SRC, src});
      issue({mmn_pkg::OPC_MOVE_DST, dst});
      issue(16'h0000);
    end
    repeat (8) @(posedge i_ref_clk);
    tally("pending_notes", 20'h00000, 20'(q_rd.size() + q_wr.size() + q_reg.size()));
    results();
  end
endmodule // mmn_exec_tb_top
